/* File: rtl/t8pw_defs.vh */
/*
 * Shared constants of the 8-bit timer output compare and PWM block:
 * register indices, field positions, mode and action codes, prescale figures.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef T8PW_DEFS_VH
`define T8PW_DEFS_VH

// ****************************************
// Register indices on the 2-bit address port
// ****************************************
`define T8PW_ADDR_CTRL       2'h0
`define T8PW_ADDR_COUNT      2'h1
`define T8PW_ADDR_COMPARE    2'h2
`define T8PW_ADDR_FLAGS      2'h3

// ****************************************
// Control register fields
// ****************************************
`define T8PW_CS_LSB          0
`define T8PW_CS_MSB          2
`define T8PW_WGM_LSB         3
`define T8PW_WGM_MSB         4
`define T8PW_COM_LSB         5
`define T8PW_COM_MSB         6
`define T8PW_FORCE_BIT       7

// ****************************************
// Flag register fields
// ****************************************
`define T8PW_OVF_BIT         0
`define T8PW_CMF_BIT         1

// ****************************************
// Waveform modes and output actions
// ****************************************
`define T8PW_WGM_NORMAL      2'h0
`define T8PW_WGM_PHASE       2'h1
`define T8PW_WGM_CTC         2'h2
`define T8PW_WGM_FAST        2'h3
`define T8PW_COM_OFF         2'h0
`define T8PW_COM_TOGGLE      2'h1
`define T8PW_COM_CLEAR       2'h2
`define T8PW_COM_SET         2'h3

// ****************************************
// Counter limits and clock sources
// ****************************************
`define T8PW_MAX             8'hFF
`define T8PW_BOTTOM          8'h00
`define T8PW_CS_STOP         3'h0
`define T8PW_CS_DIV1         3'h1
`define T8PW_CS_DIV8         3'h2
`define T8PW_CS_DIV64        3'h3
`define T8PW_CS_DIV256       3'h4
`define T8PW_CS_DIV1024      3'h5
`define T8PW_PRE_WIDTH       10
`define T8PW_PRE_MASK8       10'h007
`define T8PW_PRE_MASK64      10'h03F
`define T8PW_PRE_MASK256     10'h0FF
`define T8PW_PRE_MASK1024    10'h3FF

`endif

/* File: rtl/t8pw_prescaler.v */
/*
 * Prescaler: turns the system clock into a one-cycle timer tick enable.
 * Assumes the clock source code is held stable by the register logic.
 */
`timescale 1ns/100ps
`include "t8pw_defs.vh"

module t8pw_prescaler (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Selection
    input  wire [2:0] clock_source,
    // Timer tick enable
    output reg        tick
);

    reg  [`T8PW_PRE_WIDTH-1:0] pre_count;
    reg                        next_tick;

    // ****************************************
    // Free-running divider
    // ****************************************
    // Shared divider is never restarted, so the first tick after a start may be early
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_count <= {`T8PW_PRE_WIDTH{1'b0}};
            tick      <= 1'b0;
        end else begin
            pre_count <= pre_count + {{(`T8PW_PRE_WIDTH-1){1'b0}}, 1'b1};
            tick      <= next_tick;
        end
    end

    always @* begin
        case (clock_source)
            `T8PW_CS_DIV1:    next_tick = 1'b1;
            `T8PW_CS_DIV8:    next_tick = (pre_count & `T8PW_PRE_MASK8) == `T8PW_PRE_MASK8;
            `T8PW_CS_DIV64:   next_tick = (pre_count & `T8PW_PRE_MASK64) == `T8PW_PRE_MASK64;
            `T8PW_CS_DIV256:  next_tick = (pre_count & `T8PW_PRE_MASK256) == `T8PW_PRE_MASK256;
            `T8PW_CS_DIV1024: next_tick = pre_count == `T8PW_PRE_MASK1024;
            default:          next_tick = 1'b0;
        endcase
    end

endmodule // t8pw_prescaler

/* File: rtl/t8pw_timer.v */
/*
 * 8-bit timer with output compare: counter, buffered compare value,
 * force strobe, match blocking, clear-on-match toggling and fast PWM.
 * Assumes a single 40 MHz clock, synchronous inputs and a CPU that uses
 * one-cycle read and write strobes with read data taken one cycle later.
 */
// The address-and-strobe port and the address map were left to the implementer.
// Functional notes
// - compare value buffered only in PWM modes
// - buffer loads active compare at counter bottom
// - CPU reaches buffer or active per mode
// - force strobe acts like match, non-PWM only
// - count write blocks match next timer tick
// - output level kept across mode changes
// - output action bits act at once
// - late compare write waits for wraparound
// - action one toggles output per match
// - pin driven only when direction output
// - prescale 1, 8, 64, 256, 1024
// - overflow flag set on max-to-zero pass
// - mode three is fast PWM
// - fast PWM clears counter after max
// - fast PWM clear/set at match and bottom
// - match sets flag at next tick
// - flag cleared by acknowledge or writing one
// - count write beats clear and count
// - clock source zero stops the timer
`timescale 1ns/100ps
`include "t8pw_defs.vh"

module t8pw_timer (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Register port
    input  wire [1:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    // Interrupt acknowledges
    input  wire       overflow_ack,
    input  wire       compare_ack,
    // Flags
    output reg        overflow_flag,
    output reg        compare_match_flag,
    // Port pin
    input  wire       pin_dir_out,
    input  wire       port_value,
    output reg        pin_out,
    output reg        pin_oe
);

    // ****************************************
    // Decoding functions
    // ****************************************
    function is_pwm;
        input [1:0] mode;
        begin
            is_pwm = (mode == `T8PW_WGM_PHASE) || (mode == `T8PW_WGM_FAST);
        end
    endfunction

    // New level on a non-PWM match or force
    function match_level;
        input [1:0] action;
        input       level;
        begin
            case (action)
                `T8PW_COM_TOGGLE: match_level = ~level;
                `T8PW_COM_CLEAR:  match_level = 1'b0;
                `T8PW_COM_SET:    match_level = 1'b1;
                default:          match_level = level;
            endcase
        end
    endfunction

    // Whether the compare output replaces the port value
    function pin_connected;
        input [1:0] mode;
        input [1:0] action;
        begin
            if (action == `T8PW_COM_OFF) begin
                pin_connected = 1'b0;
            end else if (is_pwm(mode) && action == `T8PW_COM_TOGGLE) begin
                pin_connected = 1'b0;
            end else begin
                pin_connected = 1'b1;
            end
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg  [2:0] clock_source_field;
    reg  [1:0] waveform_mode_field;
    reg  [1:0] output_action_field;
    reg  [7:0] count_value;
    reg  [7:0] compare_value;
    reg  [7:0] compare_buffer;
    reg        compare_output;
    reg        block_match;
    wire       tick;

    // ****************************************
    // Decode
    // ****************************************
    wire       ctrl_wr      = wr && (addr == `T8PW_ADDR_CTRL);
    wire       count_wr     = wr && (addr == `T8PW_ADDR_COUNT);
    wire       compare_wr   = wr && (addr == `T8PW_ADDR_COMPARE);
    wire       flags_wr     = wr && (addr == `T8PW_ADDR_FLAGS);
    wire       pwm_on       = is_pwm(waveform_mode_field);
    wire       fast_on      = waveform_mode_field == `T8PW_WGM_FAST;
    wire       ctc_on       = waveform_mode_field == `T8PW_WGM_CTC;
    wire       at_max       = count_value == `T8PW_MAX;
    // A pending count write or one in this very cycle hides the match
    wire       match        = (count_value == compare_value) && !block_match
                              && !count_wr;
    wire       count_step   = tick && !count_wr;
    wire       wrap         = count_step && at_max;
    wire [1:0] new_mode     = wdata[`T8PW_WGM_MSB:`T8PW_WGM_LSB];
    wire [1:0] new_action   = wdata[`T8PW_COM_MSB:`T8PW_COM_LSB];
    wire       force_hit    = ctrl_wr && wdata[`T8PW_FORCE_BIT]
                              && !is_pwm(new_mode);

    // ****************************************
    // Timer clock
    // ****************************************
    t8pw_prescaler u_prescaler (
        .clk          (clk),
        .reset        (reset),
        .clock_source (clock_source_field),
        .tick         (tick)
    );

    // ****************************************
    // Control register
    // ****************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            clock_source_field  <= `T8PW_CS_STOP;
            waveform_mode_field <= `T8PW_WGM_NORMAL;
            output_action_field <= `T8PW_COM_OFF;
        end else if (ctrl_wr) begin
            clock_source_field  <= wdata[`T8PW_CS_MSB:`T8PW_CS_LSB];
            waveform_mode_field <= new_mode;
            output_action_field <= new_action;
        end
    end

    // ****************************************
    // Counter
    // ****************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            count_value <= `T8PW_BOTTOM;
        end else if (count_wr) begin
            count_value <= wdata;
        end else if (tick) begin
            if (ctc_on && match) begin
                count_value <= `T8PW_BOTTOM;
            end else if (fast_on && at_max) begin
                count_value <= `T8PW_BOTTOM;
            end else begin
                // A compare value below the count is passed
                count_value <= count_value + 8'h01;
            end
        end
    end

    // Count write arms the block until the next timer tick
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            block_match <= 1'b0;
        end else if (count_wr) begin
            block_match <= 1'b1;
        end else if (tick) begin
            block_match <= 1'b0;
        end
    end

    // ****************************************
    // Compare value and its buffer
    // ****************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            compare_buffer <= 8'h00;
        end else if (compare_wr) begin
            compare_buffer <= wdata;
        end
    end

    // Loading only at bottom keeps every PWM period whole
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            compare_value <= 8'h00;
        end else if (compare_wr && !pwm_on) begin
            compare_value <= wdata;
        end else if (pwm_on && wrap) begin
            compare_value <= compare_buffer;
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    // Hardware set wins over a clear in the same cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (overflow_ack || (flags_wr && wdata[`T8PW_OVF_BIT])) begin
            overflow_flag <= 1'b0;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            compare_match_flag <= 1'b0;
        end else if (tick && match) begin
            compare_match_flag <= 1'b1;
        end else if (compare_ack || (flags_wr && wdata[`T8PW_CMF_BIT])) begin
            compare_match_flag <= 1'b0;
        end
    end

    // ****************************************
    // Waveform output
    // ****************************************
    // Mode changes never touch this register
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            compare_output <= 1'b0;
        end else if (force_hit) begin
            compare_output <= match_level(new_action, compare_output);
        end else if (tick) begin
            if (fast_on) begin
                if (wrap && output_action_field == `T8PW_COM_CLEAR) begin
                    compare_output <= 1'b1;
                end else if (wrap && output_action_field == `T8PW_COM_SET) begin
                    compare_output <= 1'b0;
                end else if (match && output_action_field == `T8PW_COM_CLEAR) begin
                    compare_output <= 1'b0;
                end else if (match && output_action_field == `T8PW_COM_SET) begin
                    compare_output <= 1'b1;
                end
            end else if (!pwm_on && match) begin
                // Action bits used live, not latched with the compare value
                compare_output <= match_level(output_action_field,
                                              compare_output);
            end
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_oe  <= pin_dir_out;
            if (pin_connected(waveform_mode_field, output_action_field)) begin
                pin_out <= compare_output;
            end else begin
                pin_out <= port_value;
            end
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `T8PW_ADDR_CTRL:    rdata <= {1'b0, output_action_field,
                                              waveform_mode_field, clock_source_field};
                `T8PW_ADDR_COUNT:   rdata <= count_value;
                `T8PW_ADDR_COMPARE: rdata <= pwm_on ? compare_buffer
                                                    : compare_value;
                `T8PW_ADDR_FLAGS:   rdata <= {6'h00, compare_match_flag, overflow_flag};
                default:            rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule // t8pw_timer

/* File: verification/t8pw_pin_model.sv */
/*
 * Port pin partner: resolves the pad level from the timer's pin drive.
 * Assumes one system clock; the pad has no pull resistor.
 */
`timescale 1ns/100ps

module t8pw_pin_model (
    // Clock
    input  wire  clk,
    // Pin drive
    input  wire  pin_out,
    input  wire  pin_oe,
    // Pad
    output logic pad
);
    logic last;
    always @(posedge clk) begin
        if (pin_oe)
            last <= pin_out;
    end
    // Undriven pad shows the inverse so a stale level never passes
    assign pad = pin_oe ? pin_out : ~last;
endmodule // t8pw_pin_model

/* File: verification/t8pw_timer_chk.sv */
/*
 * Checker for the timer: pin, flag and force relations at the top ports.
 * Assumes one clock and bind onto every t8pw_timer instance.
 */
`timescale 1ns/100ps
`include "t8pw_defs.vh"

module t8pw_timer_chk (
    // Clock and reset
    input wire       clk,
    input wire       reset,
    // Register port
    input wire [1:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    // Acknowledges and flags
    input wire       overflow_ack,
    input wire       compare_ack,
    input wire       overflow_flag,
    input wire       compare_match_flag,
    // Pin
    input wire       pin_dir_out,
    input wire       port_value,
    input wire       pin_out,
    input wire       pin_oe
);
    // ****************************************
    // Shadow of the control register
    // ****************************************
    logic [7:0] ctl;
    always @(posedge clk or posedge reset) begin
        if (reset)
            ctl <= 8'h00;
        else if (wr && addr == `T8PW_ADDR_CTRL)
            ctl <= wdata;
    end
    wire act0  = ctl[6:5] == 2'h0;
    wire stop  = ctl[2:0] == 3'h0 || ctl[2:0] > 3'h5;
    wire clr_c = wr && addr == `T8PW_ADDR_FLAGS && wdata[`T8PW_CMF_BIT];
    wire clr_o = wr && addr == `T8PW_ADDR_FLAGS && wdata[`T8PW_OVF_BIT];

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Force write in a non-PWM mode with a set or clear action
    sequence force_wr;
        wr && addr == `T8PW_ADDR_CTRL && wdata[7] && !wdata[3] && wdata[6];
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    oe_follow_a: assert property (pin_oe == $past(pin_dir_out))
        else $error("pin enable does not follow direction");
    port_pass_a: assert property ($past(act0) |-> pin_out == $past(port_value))
        else $error("port value not passed while action off");
    cmf_hold_a: assert property (compare_match_flag && !compare_ack && !clr_c
        |=> compare_match_flag) else $error("compare flag lost");
    ovf_hold_a: assert property (overflow_flag && !overflow_ack && !clr_o
        |=> overflow_flag) else $error("overflow flag lost");
    cmf_clear_a: assert property ($fell(compare_match_flag)
        |-> $past(compare_ack || clr_c)) else $error("compare flag cleared alone");
    ovf_clear_a: assert property ($fell(overflow_flag)
        |-> $past(overflow_ack || clr_o)) else $error("overflow flag cleared alone");
    force_level_a: assert property (force_wr |-> ##2 pin_out == $past(wdata[5], 2))
        else $error("forced level not on pin");
    stop_quiet_a: assert property (stop && $past(stop)
        |=> !$rose(compare_match_flag) && !$rose(overflow_flag))
        else $error("flag set while stopped");
endmodule // t8pw_timer_chk

bind t8pw_timer t8pw_timer_chk i_chk (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .overflow_ack(overflow_ack), .compare_ack(compare_ack),
    .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag),
    .pin_dir_out(pin_dir_out), .port_value(port_value), .pin_out(pin_out),
    .pin_oe(pin_oe)
);

/* File: verification/t8pw_timer_bench.sv */
/*
 * Self-checking bench for the timer: registers, CLEAR_ON_MATCH_MODE, fast PWM, prescaler.
 * Assumes a 40 MHz clock and the pin partner model on the pin drive.
 */
`timescale 1ns/100ps
`include "t8pw_defs.vh"

module t8pw_timer_bench;
    logic        clk, reset, wr, rd, overflow_ack, compare_ack;
    logic        pin_dir_out, port_value, p;
    logic [1:0]  addr;
    logic [7:0]  wdata, v, r, c, d;
    logic [11:0] t;
    wire  [7:0]  rdata;
    wire         overflow_flag, compare_match_flag, pin_out, pin_oe, pad;
    int          seed, i, k, n, miscompares, num_checks;

    t8pw_timer i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .overflow_ack(overflow_ack),
        .compare_ack(compare_ack), .overflow_flag(overflow_flag),
        .compare_match_flag(compare_match_flag), .pin_dir_out(pin_dir_out),
        .port_value(port_value), .pin_out(pin_out), .pin_oe(pin_oe));
    t8pw_pin_model i_pin (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

    // ****************************************
    // Tasks
    // ****************************************
    task check(input string nm, input [11:0] s, input [11:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wr_reg(input [1:0] a, input [7:0] x);
        @(posedge clk);
        addr <= a; wdata <= x; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input [1:0] a, output [7:0] x);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 x = rdata;
    endtask
    // Cycles until the pin reaches a level, bounded so a dead pin cannot hang
    task wait_pin(input lv, output [11:0] cnt);
        cnt = 0;
        while (pin_out !== lv && cnt < 3000) begin
            @(posedge clk);
            #1 cnt++;
        end
    endtask
    task summarize;
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        summarize;
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        seed = 60; miscompares = 0; num_checks = 0; reset = 1'b1;
        {addr, wdata, wr, rd, overflow_ack, compare_ack, pin_dir_out, port_value} = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 4; i++) begin
            rd_reg(i[1:0], v);
            check("reset reg", v, 0);
        end
        check("pin enable", pin_oe, 0);
        r = $random(seed);
        wr_reg(`T8PW_ADDR_COUNT, r);
        repeat (20) begin
            @(posedge clk);
            port_value <= $random(seed);
        end
        rd_reg(`T8PW_ADDR_COUNT, v);
        check("stopped count", v, r);
        // Output level set by force before the pin turns to output
        wr_reg(`T8PW_ADDR_CTRL, 8'hE0);
        check("force flag", compare_match_flag, 0);
        pin_dir_out <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check("pad forced", pad, 1);
        // CLEAR_ON_MATCH_MODE toggling, count cleared while stopped and away from compare
        c = {4'h0, r[3:0]} + 8'h02;
        wr_reg(`T8PW_ADDR_COMPARE, c);
        wr_reg(`T8PW_ADDR_COUNT, 8'h00);
        wr_reg(`T8PW_ADDR_CTRL, 8'h31);
        wait_pin(~pin_out, t);
        wait_pin(~pin_out, t);
        check("ctc half period", t, c + 8'h01);
        check("ctc flag", compare_match_flag, 1);
        wr_reg(`T8PW_ADDR_CTRL, 8'h30);
        wr_reg(`T8PW_ADDR_FLAGS, 8'h02);
        #1 check("flag write one", compare_match_flag, 0);
        // Late compare, then count written equal to compare: both wait for wrap
        for (k = 0; k < 2; k++) begin
            r = $random(seed);
            wr_reg(`T8PW_ADDR_FLAGS, 8'h03);
            wr_reg(`T8PW_ADDR_COMPARE, k ? r : 8'h0A);
            wr_reg(`T8PW_ADDR_COUNT, k ? r : 8'h32);
            wr_reg(`T8PW_ADDR_CTRL, 8'h31);
            t = 0;
            while (compare_match_flag !== 1'b1 && t < 600) begin
                @(posedge clk);
                #1 t++;
            end
            check("wrap before match", overflow_flag, 1);
            wr_reg(`T8PW_ADDR_CTRL, 8'h30);
        end
        @(posedge clk);
        {overflow_ack, compare_ack} <= 2'h3;
        @(posedge clk);
        {overflow_ack, compare_ack} <= 2'h0;
        #1 check("ack clears", {overflow_flag, compare_match_flag}, 0);
        // Fast PWM, non-inverting then inverting; new compare mid-pulse
        for (k = 0; k < 2; k++) begin
            r = $random(seed);
            d = 8'h10 + {1'b0, r[6:0]};
            p = ~k[0];
            wr_reg(`T8PW_ADDR_COMPARE, d);
            wr_reg(`T8PW_ADDR_CTRL, k ? 8'h79 : 8'h59);
            wait_pin(~p, t);
            wait_pin(p, t);
            wr_reg(`T8PW_ADDR_COMPARE, 8'h01);
            wait_pin(~p, t);
            check("pwm old pulse", t + 12'h002, d + 8'h01);
            wait_pin(p, t);
            check("pwm rest", t, 8'hFF - d);
            wait_pin(~p, t);
            check("pwm new pulse", t, 2);
            rd_reg(`T8PW_ADDR_COMPARE, v);
            check("buffer read", v, 8'h01);
            check("pwm overflow", overflow_flag, 1);
            wr_reg(`T8PW_ADDR_FLAGS, 8'h03);
        end
        p = pin_out;
        wr_reg(`T8PW_ADDR_CTRL, 8'h40);
        repeat (3) @(posedge clk);
        #1 check("mode change keeps", pin_out, p);
        wr_reg(`T8PW_ADDR_CTRL, 8'h00);
        port_value <= ~p;
        repeat (3) @(posedge clk);
        #1 check("action off at once", pin_out, !p);
        pin_dir_out <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("pin released", pin_oe, 0);
        // Prescale factors 8, 64, 256 and 1024 over four ticks each
        for (k = 2; k < 6; k++) begin
            n = (k == 2) ? 8 : (1 << (2 * k));
            wr_reg(`T8PW_ADDR_COUNT, 8'h00);
            wr_reg(`T8PW_ADDR_CTRL, k[7:0]);
            repeat (4 * n) @(posedge clk);
            rd_reg(`T8PW_ADDR_COUNT, v);
            check("prescale ticks", v >= 8'h03 && v <= 8'h05, 1);
            wr_reg(`T8PW_ADDR_CTRL, 8'h00);
        end
        summarize;
    end
endmodule // t8pw_timer_bench
